// file: src/srp_pkg.sv
/*
  Constants, register map and carrier types for the synthesizer reference path
  configuration bank. Assumes nothing beyond a SystemVerilog compiler.
*/
package srp_pkg;
    // ------------------------------------------------------------
    // Serial frame layout: read flag, 7-bit address, 16-bit data
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 16;
    localparam int HEAD_BITS = 8;
    localparam int RW_POS = 23;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_CAL_CONTROL = 7'h00;
    localparam logic [6:0] ADDR_CALIBRATION_OVERRIDE = 7'h08;
    localparam logic [6:0] ADDR_REFERENCE_PATH_CONTROL = 7'h09;
    localparam logic [6:0] ADDR_REFERENCE_MULTIPLIER = 7'h0A;
    localparam logic [6:0] ADDR_REFERENCE_POST_DIVIDER = 7'h0B;
    localparam logic [6:0] ADDR_REFERENCE_PRE_DIVIDER = 7'h0C;
    localparam logic [6:0] ADDR_PUMP_DETECTOR_CONTROL = 7'h0D;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AMPLITUDE_OVERRIDE_POS = 13;
    localparam int CAPBANK_OVERRIDE_POS = 10;
    localparam int FREQ_CAL_ENABLE_POS = 3;
    localparam int REF_DOUBLER_POS = 11;
    localparam int REF_ENABLE_POS = 9;
    localparam int REF_MULTIPLIER_HI = 11;
    localparam int REF_MULTIPLIER_LO = 7;
    localparam int POST_DIV_HI = 11;
    localparam int POST_DIV_LO = 4;
    localparam int PRE_DIV_HI = 11;
    localparam int PRE_DIV_LO = 0;
    localparam int PUMP_ENABLE_POS = 14;
    localparam int DETECTOR_MODE_HI = 1;
    localparam int DETECTOR_MODE_LO = 0;
    localparam int CAPBANK_CODE_BITS = 8;

    // ------------------------------------------------------------
    // Reset values of whole registers
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CALIBRATION_OVERRIDE = 16'h0000;
    localparam logic [15:0] RST_REFERENCE_PATH_CONTROL = 16'h0200;
    localparam logic [15:0] RST_REFERENCE_MULTIPLIER = 16'h0080;
    localparam logic [15:0] RST_REFERENCE_POST_DIVIDER = 16'h0010;
    localparam logic [15:0] RST_REFERENCE_PRE_DIVIDER = 16'h0001;
    localparam logic [15:0] RST_PUMP_DETECTOR_CONTROL = 16'h4000;

    // ------------------------------------------------------------
    // Detector modes
    // ------------------------------------------------------------
    localparam logic [1:0] DETECTOR_DUAL = 2'h0;
    localparam logic [1:0] DETECTOR_SINGLE = 2'h3;

    typedef struct packed {
        logic doubler_enable;
        logic path_enable;
        logic [4:0] multiplier;
        logic [7:0] post_divider;
        logic [11:0] pre_divider;
    } srp_ref_path_type;

    typedef struct packed {
        logic amplitude_override;
        logic capbank_override;
        logic amplitude_cal_active;
        logic [8:0] vco_amplitude;
        logic [7:0] vco_capbank;
        logic [2:0] vco_core;
    } srp_vco_ctrl_type;
endpackage

// file: src/srp_config_regs.sv
/*
  Configuration register bank of the reference path, calibration overrides,
  charge pump and phase detector, written and read over the four-wire serial
  port. Assumes the serial pins are asynchronous to clk and toggle slowly
  enough that each level lasts at least four clk periods.
*/
`timescale 1ns/1ps
module srp_config_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial programming pins
    input wire logic spi_csb_n,
    input wire logic spi_sck,
    input wire logic spi_sdi,
    output logic spi_readback,
    // Values owned by neighbouring registers
    input wire logic amplitude_cal_enable,
    input wire logic [8:0] amplitude_code,
    input wire logic [7:0] capbank_code,
    input wire logic core_select_force,
    input wire logic [2:0] core_select,
    // Configuration outputs
    output srp_pkg::srp_ref_path_type ref_path,
    output srp_pkg::srp_vco_ctrl_type vco_ctrl,
    output logic pump_enable,
    output logic [1:0] detector_mode,
    output logic freq_cal_start
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Pins are {chip select, clock, data}. A level counts once the second
    // and third stages agree, which also rejects a single-sample glitch.
    logic [2:0] pins_in;
    logic [2:0] sync_a_reg;
    logic [2:0] sync_b_reg;
    logic [2:0] sync_c_reg;
    logic [2:0] stable_reg;
    logic [2:0] stable_next;

    assign pins_in = {spi_csb_n, spi_sck, spi_sdi};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            assign stable_next[gi] = (sync_b_reg[gi] == sync_c_reg[gi]) ?
                                     sync_c_reg[gi] : stable_reg[gi];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_a_reg <= 3'h5;
            sync_b_reg <= 3'h5;
            sync_c_reg <= 3'h5;
            stable_reg <= 3'h5;
        end else begin
            sync_a_reg <= pins_in;
            sync_b_reg <= sync_a_reg;
            sync_c_reg <= sync_b_reg;
            stable_reg <= stable_next;
        end
    end

    logic cs_active;
    logic sck_rise;
    logic sck_fall;
    logic cs_end;

    assign cs_active = ~stable_reg[2];
    assign sck_rise = cs_active & ~stable_reg[1] & stable_next[1];
    assign sck_fall = cs_active & stable_reg[1] & ~stable_next[1];
    assign cs_end = cs_active & stable_next[2];

    // ------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic [15:0] out_reg;
    logic [15:0] out_next;
    logic readback_next;

    assign shift_next = sck_rise ? {shift_reg[22:0], stable_reg[0]} : shift_reg;
    assign count_next = cs_end ? 5'h00 :
                        (sck_rise && count_reg != 5'(srp_pkg::FRAME_BITS)) ?
                        count_reg + 5'h01 : count_reg;

    // Register file.
    logic [15:0] cal_ovr_reg;
    logic [15:0] ref_ctl_reg;
    logic [15:0] ref_multiplier_reg;
    logic [15:0] post_reg;
    logic [15:0] pre_reg;
    logic [15:0] pump_reg;

    // The header is complete on the rising edge that takes its eighth bit;
    // on a read, the addressed register is frozen into the output shifter then.
    logic head_done;
    logic is_read;
    logic [6:0] head_addr;
    logic [15:0] read_data;

    assign head_done = sck_rise && count_reg == 5'(srp_pkg::HEAD_BITS - 1);
    assign is_read = shift_next[7];
    assign head_addr = shift_next[6:0];

    always_comb begin
        case (head_addr)
            srp_pkg::ADDR_CALIBRATION_OVERRIDE: read_data = cal_ovr_reg;
            srp_pkg::ADDR_REFERENCE_PATH_CONTROL: read_data = ref_ctl_reg;
            srp_pkg::ADDR_REFERENCE_MULTIPLIER: read_data = ref_multiplier_reg;
            srp_pkg::ADDR_REFERENCE_POST_DIVIDER: read_data = post_reg;
            srp_pkg::ADDR_REFERENCE_PRE_DIVIDER: read_data = pre_reg;
            srp_pkg::ADDR_PUMP_DETECTOR_CONTROL: read_data = pump_reg;
            default: read_data = 16'h0000;
        endcase
    end

    // Readback data is loaded on the eighth rising edge and then changes on falling
    // clock edges, so the host can sample each later bit on the following rising edge.
    assign out_next = (head_done && is_read) ? read_data :
                      sck_fall ? {out_reg[14:0], 1'b0} : out_reg;
    assign readback_next = cs_active ? out_reg[15] : 1'b0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_reg <= 24'h000000;
            count_reg <= 5'h00;
            out_reg <= 16'h0000;
            spi_readback <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            count_reg <= count_next;
            out_reg <= out_next;
            spi_readback <= readback_next;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Writes land only when chip select rises after at least a full frame, so
    // a truncated frame changes nothing and an overlong one writes its last 24 bits.
    logic commit;
    logic [6:0] wr_addr;
    logic [15:0] wr_data;

    assign commit = cs_end && count_reg == 5'(srp_pkg::FRAME_BITS) &&
                    !shift_reg[srp_pkg::RW_POS];
    assign wr_addr = shift_reg[22:16];
    assign wr_data = shift_reg[15:0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cal_ovr_reg <= srp_pkg::RST_CALIBRATION_OVERRIDE;
            ref_ctl_reg <= srp_pkg::RST_REFERENCE_PATH_CONTROL;
            ref_multiplier_reg <= srp_pkg::RST_REFERENCE_MULTIPLIER;
            post_reg <= srp_pkg::RST_REFERENCE_POST_DIVIDER;
            pre_reg <= srp_pkg::RST_REFERENCE_PRE_DIVIDER;
            pump_reg <= srp_pkg::RST_PUMP_DETECTOR_CONTROL;
        end else if (commit) begin
            // Unnamed bits are stored as written and read back unchanged.
            case (wr_addr)
                srp_pkg::ADDR_CALIBRATION_OVERRIDE: cal_ovr_reg <= wr_data;
                srp_pkg::ADDR_REFERENCE_PATH_CONTROL: ref_ctl_reg <= wr_data;
                srp_pkg::ADDR_REFERENCE_MULTIPLIER: ref_multiplier_reg <= wr_data;
                srp_pkg::ADDR_REFERENCE_POST_DIVIDER: post_reg <= wr_data;
                srp_pkg::ADDR_REFERENCE_PRE_DIVIDER: pre_reg <= wr_data;
                srp_pkg::ADDR_PUMP_DETECTOR_CONTROL: pump_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Derived controls
    // ------------------------------------------------------------
    logic amp_ovr;
    logic cap_ovr;
    logic cal_req;
    srp_pkg::srp_ref_path_type ref_path_next;
    srp_pkg::srp_vco_ctrl_type vco_next;

    assign amp_ovr = cal_ovr_reg[srp_pkg::AMPLITUDE_OVERRIDE_POS];
    assign cap_ovr = cal_ovr_reg[srp_pkg::CAPBANK_OVERRIDE_POS];
    // Calibration bit writes go to the neighbouring control register; only
    // the launch pulse is produced here.
    assign cal_req = commit && wr_addr == srp_pkg::ADDR_CAL_CONTROL &&
                     wr_data[srp_pkg::FREQ_CAL_ENABLE_POS];

    assign ref_path_next.doubler_enable = ref_ctl_reg[srp_pkg::REF_DOUBLER_POS];
    assign ref_path_next.path_enable = ref_ctl_reg[srp_pkg::REF_ENABLE_POS];
    assign ref_path_next.multiplier = ref_multiplier_reg[srp_pkg::REF_MULTIPLIER_HI:srp_pkg::REF_MULTIPLIER_LO];
    assign ref_path_next.post_divider = post_reg[srp_pkg::POST_DIV_HI:srp_pkg::POST_DIV_LO];
    assign ref_path_next.pre_divider = pre_reg[srp_pkg::PRE_DIV_HI:srp_pkg::PRE_DIV_LO];

    assign vco_next.amplitude_override = amp_ovr;
    assign vco_next.capbank_override = cap_ovr;
    assign vco_next.amplitude_cal_active = amplitude_cal_enable & ~amp_ovr;
    assign vco_next.vco_amplitude = amp_ovr ? amplitude_code : 9'h000;
    assign vco_next.vco_capbank = cap_ovr ? capbank_code : 8'h00;
    // Core choice applies only under bank override, so force without one is ignored.
    assign vco_next.vco_core = (cap_ovr && core_select_force) ? core_select : 3'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_path <= '0;
            vco_ctrl <= '0;
            pump_enable <= 1'b0;
            detector_mode <= srp_pkg::DETECTOR_DUAL;
            freq_cal_start <= 1'b0;
        end else begin
            ref_path <= ref_path_next;
            vco_ctrl <= vco_next;
            pump_enable <= pump_reg[srp_pkg::PUMP_ENABLE_POS];
            detector_mode <= pump_reg[srp_pkg::DETECTOR_MODE_HI:srp_pkg::DETECTOR_MODE_LO];
            freq_cal_start <= cal_req & ~cap_ovr;
        end
    end
endmodule

// file: verification/srp_config_regs_chk.sv
/*
  Port checker for the reference path configuration bank.
  Assumes the host keeps chip select high between frames; attached by bind.
*/
`timescale 1ns/1ps
module srp_config_regs_chk (
    // Clock, reset and serial pins
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_csb_n,
    input wire logic spi_sck,
    input wire logic spi_sdi,
    input wire logic spi_readback,
    // Neighbour register values
    input wire logic amplitude_cal_enable,
    input wire logic [8:0] amplitude_code,
    input wire logic [7:0] capbank_code,
    input wire logic core_select_force,
    input wire logic [2:0] core_select,
    // Configuration outputs
    input wire srp_pkg::srp_ref_path_type ref_path,
    input wire srp_pkg::srp_vco_ctrl_type vco_ctrl,
    input wire logic pump_enable,
    input wire logic [1:0] detector_mode,
    input wire logic freq_cal_start
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_AMP_CODE: assert property (
        vco_ctrl.amplitude_override |-> vco_ctrl.vco_amplitude == $past(amplitude_code))
        else $error("amplitude code not passed through");
    AST_CAL_ACTIVE: assert property (
        $past(rst_n) |-> vco_ctrl.amplitude_cal_active == ($past(amplitude_cal_enable)
            && !vco_ctrl.amplitude_override))
        else $error("amplitude calibration not skipped");
    AST_CAP_CODE: assert property (
        vco_ctrl.capbank_override |-> vco_ctrl.vco_capbank == $past(capbank_code))
        else $error("bank code not passed through");
    AST_CORE: assert property (
        vco_ctrl.vco_core == ((vco_ctrl.capbank_override && $past(core_select_force))
            ? $past(core_select) : 3'h0))
        else $error("core choice wrong");
    AST_CAL_PULSE: assert property (freq_cal_start |=> !freq_cal_start)
        else $error("calibration start longer than one cycle");
    AST_CAL_BLOCK: assert property (freq_cal_start |-> !vco_ctrl.capbank_override)
        else $error("calibration started under bank override");
    AST_RB_IDLE: assert property (spi_csb_n [*8] |-> !spi_readback)
        else $error("readback driven while deselected");
    AST_HOLD: assert property (spi_csb_n [*8] ##1 spi_csb_n |=>
        $stable(ref_path) && $stable(pump_enable) && $stable(detector_mode))
        else $error("configuration changed without a frame");
    cover property (vco_ctrl.capbank_override && vco_ctrl.vco_core != 3'h0);
    cover property (freq_cal_start);
    cover property (detector_mode == 2'h3);
endmodule
bind srp_config_regs srp_config_regs_chk u_chk (
    .clk(clk), .rst_n(rst_n), .spi_csb_n(spi_csb_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
    .spi_readback(spi_readback), .amplitude_cal_enable(amplitude_cal_enable),
    .amplitude_code(amplitude_code), .capbank_code(capbank_code),
    .core_select_force(core_select_force), .core_select(core_select), .ref_path(ref_path),
    .vco_ctrl(vco_ctrl), .pump_enable(pump_enable), .detector_mode(detector_mode),
    .freq_cal_start(freq_cal_start)
);

// file: verification/srp_host_model.sv
/*
  Host side of the four-wire programming port.
  Assumes clk is the bench clock and one caller at a time.
*/
`timescale 1ns/1ps
module srp_host_model (
    // Bench clock
    input wire logic clk,
    // Serial pins
    output logic spi_csb_n,
    output logic spi_sck,
    output logic spi_sdi,
    input wire logic spi_readback
);
    // ----------
    // Frame task
    // ----------
    initial begin
        spi_csb_n = 1'b1;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
    end
    // Six clk per level leaves margin over the four that the synchroniser needs.
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d,
                        input int nbits, output logic [15:0] q);
        logic [23:0] f;
        f = {rd, a, d};
        q = 16'h0000;
        repeat (6) @(posedge clk);
        #1 spi_csb_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_sdi = f[23 - i];
            repeat (6) @(posedge clk);
            #1 spi_sck = 1'b1;
            repeat (6) @(posedge clk);
            #1;
            // Each readback bit stands from a falling edge until the next falling one; the first from the eighth rising edge.
            if (i >= 7 && i < 23) q = {q[14:0], spi_readback};
            spi_sck = 1'b0;
        end
        repeat (6) @(posedge clk);
        #1 spi_csb_n = 1'b1;
        spi_sdi = ~spi_sdi;
    endtask
endmodule

// file: verification/srp_config_regs_tb.sv
/*
  Self-checking bench for the reference path configuration bank.
  Assumes srp_host_model drives the serial pins.
*/
`timescale 1ns/1ps
module srp_config_regs_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic amplitude_cal_enable = 1'b1;
    logic [8:0] amplitude_code = 9'h12C;
    logic [7:0] capbank_code = 8'h5A;
    logic core_select_force = 1'b1;
    logic [2:0] core_select = 3'h5;
    logic spi_csb_n, spi_sck, spi_sdi, spi_readback, pump_enable, freq_cal_start;
    logic [1:0] detector_mode;
    logic [15:0] q;
    srp_pkg::srp_ref_path_type ref_path;
    srp_pkg::srp_vco_ctrl_type vco_ctrl;
    int n_fail = 0;
    int comparisons = 0;
    int n_pulse = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (freq_cal_start === 1'b1) n_pulse++;
    srp_host_model host (.clk(clk), .spi_csb_n(spi_csb_n), .spi_sck(spi_sck),
        .spi_sdi(spi_sdi), .spi_readback(spi_readback));
    srp_config_regs dut (.clk(clk), .rst_n(rst_n), .spi_csb_n(spi_csb_n), .spi_sck(spi_sck),
        .spi_sdi(spi_sdi), .spi_readback(spi_readback), .amplitude_code(amplitude_code),
        .amplitude_cal_enable(amplitude_cal_enable), .capbank_code(capbank_code),
        .core_select_force(core_select_force), .core_select(core_select), .vco_ctrl(vco_ctrl),
        .ref_path(ref_path), .pump_enable(pump_enable), .detector_mode(detector_mode),
        .freq_cal_start(freq_cal_start));
    // ---------------
    // Shared tasks
    // ---------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_cfg(input logic [29:0] e);
        check(32'({ref_path, pump_enable, detector_mode}), 32'(e));
    endtask
    task automatic chk_vco(input logic [22:0] e);
        check(32'(vco_ctrl), 32'(e));
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.xfer(1'b0, a, d, 24, q);
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        host.xfer(1'b1, a, 16'hA5A5, 24, q);
        check(32'(q), 32'(e));
    endtask
    task automatic conclude();
        $display("failures %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ---------------
    // Scenarios
    // ---------------
    task automatic t_reset();
        chk_cfg({2'b01, 5'h01, 8'h01, 12'h001, 1'b1, 2'h0});
        chk_vco({3'b001, 9'h000, 8'h00, 3'h0});
        rd(7'h08, 16'h0000);
        rd(7'h09, 16'h0200);
        rd(7'h0B, 16'h0010);
        rd(7'h0C, 16'h0001);
    endtask
    task automatic t_path();
        wr(7'h09, 16'h0A00);
        chk_cfg({2'b11, 5'h01, 8'h01, 12'h001, 1'b1, 2'h0});
        wr(7'h09, 16'h0000);
        wr(7'h0A, 16'h0200);
        wr(7'h0B, 16'h0FF0);
        wr(7'h0C, 16'h0FFF);
        wr(7'h0D, 16'h0003);
        chk_cfg({2'b00, 5'h04, 8'hFF, 12'hFFF, 1'b0, 2'h3});
        rd(7'h0A, 16'h0200);
        rd(7'h0D, 16'h0003);
        wr(7'h0D, 16'h4000);
        chk_cfg({2'b00, 5'h04, 8'hFF, 12'hFFF, 1'b1, 2'h0});
    endtask
    task automatic t_override();
        wr(7'h08, 16'h2000);
        chk_vco({3'b100, 9'h12C, 8'h00, 3'h0});
        amplitude_code = 9'h1C2;
        wr(7'h08, 16'h2400);
        chk_vco({3'b110, 9'h1C2, 8'h5A, 3'h5});
        core_select_force = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk_vco({3'b110, 9'h1C2, 8'h5A, 3'h0});
        wr(7'h00, 16'h0008);
        check(32'(n_pulse), 32'h0);
        wr(7'h08, 16'h0000);
        wr(7'h00, 16'h0008);
        check(32'(n_pulse), 32'h1);
        chk_vco({3'b001, 9'h000, 8'h00, 3'h0});
    endtask
    task automatic t_refuse();
        wr(7'h20, 16'hFFFF);
        rd(7'h20, 16'h0000);
        rd(7'h00, 16'h0000);
        host.xfer(1'b0, 7'h09, 16'h0A00, 23, q);
        repeat (12) @(posedge clk);
        #1;
        rd(7'h09, 16'h0000);
        wr(7'h09, 16'h0800);
        host.xfer(1'b1, 7'h09, 16'h0000, 24, q);
        repeat (12) @(posedge clk);
        #1;
        rd(7'h09, 16'h0800);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        t_reset();
        t_path();
        t_override();
        t_refuse();
        conclude();
    end
    initial begin
        #1_000_000;
        n_fail++;
        conclude();
    end
endmodule
